// *** design/ccr_defs.vh ***
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define CCR_OFF_TAIL 8'h00
`define CCR_OFF_FEAT_LO 8'h04
`define CCR_OFF_FEAT_HI 8'h08
`define CCR_OFF_REQ 8'h0c
`define CCR_OFF_RES 8'h10

// ---------------------------------------------
// card specific data tail fields
// ---------------------------------------------
`define CCR_GRP_SIZE_LSB 0
`define CCR_GRP_EN_BIT 7
`define CCR_FACTOR_LSB 8
`define CCR_WBLEN_LSB 11
`define CCR_PARTIAL_BIT 15
`define CCR_FMT_GRP_BIT 16
`define CCR_COPY_BIT 17
`define CCR_PERM_BIT 18
`define CCR_TEMP_BIT 19
`define CCR_FMT_LSB 20
`define CCR_CKSUM_LSB 22

// ---------------------------------------------
// access request and result fields
// ---------------------------------------------
`define CCR_REQ_LEN_LSB 0
`define CCR_REQ_ERASE_BIT 12
`define CCR_REQ_SECURE_BIT 13
`define CCR_RES_OK_BIT 0
`define CCR_RES_PROT_BIT 1
`define CCR_RES_LEN_BIT 2
`define CCR_RES_OVR_BIT 3

// ---------------------------------------------
// configuration register fields and codes
// ---------------------------------------------
`define CCR_LAYOUT_V10 4'h0
`define CCR_SPEC_V101 4'h0
`define CCR_SEC_PROT2 3'h2
`define CCR_SEC_NONE 3'h0
`define CCR_WIDTHS_1_4 4'h5
`define CCR_SCR_RSVD 16'h0000

// ---------------------------------------------
// block sizes and response codes
// ---------------------------------------------
`define CCR_BLK_UNIT 12'h200
`define CCR_BLEN_MIN 4'h9
`define CCR_BLEN_MAX 4'hb
`define CCR_RESP_OKAY 2'h0
`define CCR_RESP_SLVERR 2'h2

`endif

// *** design/ccr_scr_image.v ***
`timescale 1ns/1ps
`include "ccr_defs.vh"

// factory image of the 64-bit feature configuration word
module ccr_feature_image #(
	parameter ERASE_STATE = 1'b0,
	parameter SECURITY = 3'h2,
	parameter WRITABLE = 1'b1,
	parameter [31:0] MAKER_FIELD = 32'h0000_0000
) (
	// image
	output wire [63:0] featWord
);
	// a writable card must not claim no security
	wire [2:0] secCode;
	assign secCode = (WRITABLE && SECURITY == `CCR_SEC_NONE) ? `CCR_SEC_PROT2 : SECURITY;

	// fixed layout, no write path exists at all
	assign featWord = {`CCR_LAYOUT_V10,
		`CCR_SPEC_V101,
		ERASE_STATE,
		secCode,
		`CCR_WIDTHS_1_4,
		`CCR_SCR_RSVD,
		MAKER_FIELD};
endmodule

// *** design/ccr_access_check.v ***
`timescale 1ns/1ps
`include "ccr_defs.vh"

// judges one write or erase request against the protect bits
module ccr_access_check (
	// request
	input wire [11:0] reqLen,
	input wire reqErase,
	input wire reqSecure,
	// card state
	input wire permProtect,
	input wire tempProtect,
	input wire partialOk,
	input wire [3:0] blkLenCode,
	// verdict
	output wire refuseProt,
	output wire refuseLen
);
	wire [12:0] fullLen;
	wire fullOk;
	wire partOk;

	// secured area stays reachable under either protect bit
	assign refuseProt = ~reqSecure & (permProtect | tempProtect);

	// full block or a whole number of 512-byte units below it
	assign fullLen = 13'h0001 << blkLenCode;
	assign fullOk = (reqLen[8:0] == 9'h000) && (reqLen != 12'h000)
		&& ({1'b0, reqLen} <= fullLen);
	assign partOk = (reqLen != 12'h000) && ({1'b0, reqLen} <= fullLen);
	// erase carries no length
	assign refuseLen = ~reqErase & ~(partialOk ? partOk : fullOk);
endmodule

// *** design/ccr_top.v ***
`timescale 1ns/1ps
`include "ccr_defs.vh"

module ccr_top #(
	parameter [3:0] READ_BLK_LEN = 4'h9,
	parameter [6:0] GROUP_SIZE = 7'h00,
	parameter GROUP_ENABLE = 1'b1,
	parameter [2:0] PROG_FACTOR = 3'h0,
	parameter PARTIAL_WRITE = 1'b0,
	parameter IS_ROM = 1'b0,
	parameter [1:0] FORMAT_INIT = 2'h0,
	parameter [6:0] CHECKSUM_INIT = 7'h00,
	parameter ERASE_STATE = 1'b0,
	parameter [2:0] SECURITY = 3'h2,
	parameter [31:0] MAKER_FIELD = 32'h0000_0000
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// write address channel
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output wire awready,
	// write data channel
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	// write response channel
	output wire [1:0] bresp,
	output wire bvalid,
	input wire bready,
	// read address channel
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output wire arready,
	// read data channel
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	output wire rvalid,
	input wire rready,
	// card state
	output wire contentLocked,
	output wire groupProtectAvail
);
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	// byte-lane merge of a write onto a stored word
	function [31:0] laneMerge;
		input [31:0] oldWord;
		input [31:0] newWord;
		input [3:0] strb;
		integer i;
		begin
			laneMerge = oldWord;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					laneMerge[i*8 +: 8] = newWord[i*8 +: 8];
				end
			end
		end
	endfunction

	// is an offset one of ours
	function isMapped;
		input [7:0] addr;
		begin
			isMapped = (addr == `CCR_OFF_TAIL) || (addr == `CCR_OFF_FEAT_LO)
				|| (addr == `CCR_OFF_FEAT_HI) || (addr == `CCR_OFF_REQ)
				|| (addr == `CCR_OFF_RES);
		end
	endfunction

	// ---------------------------------------------
	// declarations
	// ---------------------------------------------
	reg awready_q;
	reg wready_q;
	reg awHeld_q;
	reg wHeld_q;
	reg [7:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg arready_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg fmtGroup_q;
	reg copy_q;
	reg perm_q;
	reg temp_q;
	reg [1:0] fmt_q;
	reg [6:0] cksum_q;
	reg [13:0] req_q;
	reg checkGo_q;
	reg resOk_q;
	reg resProt_q;
	reg resLen_q;
	reg overwrite_q;
	reg locked_q;
	reg groupAvail_q;
	wire awTake;
	wire wTake;
	wire doWrite;
	wire [31:0] tailWord;
	wire [31:0] resWord;
	wire [31:0] tailMerged;
	wire [31:0] resMerged;
	wire [63:0] featWord;
	wire refuseProt;
	wire refuseLen;
	wire [3:0] writeBlkLen;
	wire ovrAttempt;
	reg [31:0] readMux;

	// ---------------------------------------------
	// read-only card geometry
	// ---------------------------------------------
	// write length never differs from read length
	assign writeBlkLen = READ_BLK_LEN;

	// the tail of the card specific data as software sees it
	assign tailWord = {3'h0,
		cksum_q,
		fmt_q,
		temp_q,
		perm_q,
		copy_q,
		fmtGroup_q,
		PARTIAL_WRITE,
		writeBlkLen,
		PROG_FACTOR,
		GROUP_ENABLE,
		GROUP_SIZE};

	assign resWord = {28'h0000000, overwrite_q, resLen_q, resProt_q, resOk_q};

	// ---------------------------------------------
	// submodules
	// ---------------------------------------------
	ccr_feature_image #(
		.ERASE_STATE(ERASE_STATE),
		.SECURITY(SECURITY),
		.WRITABLE(~IS_ROM),
		.MAKER_FIELD(MAKER_FIELD)
	) ccr_feature_image_inst (
		.featWord(featWord)
	);

	ccr_access_check ccr_access_check_inst (
		.reqLen(req_q[11:0]),
		.reqErase(req_q[`CCR_REQ_ERASE_BIT]),
		.reqSecure(req_q[`CCR_REQ_SECURE_BIT]),
		.permProtect(perm_q),
		.tempProtect(temp_q),
		.partialOk(PARTIAL_WRITE),
		.blkLenCode(writeBlkLen),
		.refuseProt(refuseProt),
		.refuseLen(refuseLen)
	);

	// ---------------------------------------------
	// write address and data capture
	// ---------------------------------------------
	assign awTake = awvalid & awready_q;
	assign wTake = wvalid & wready_q;
	// both halves held and no answer pending yet
	assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;

	// each channel taken on its own, in either order
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end else begin
			if (awTake) begin
				awAddr_q <= awaddr;
				awHeld_q <= 1'b1;
				awready_q <= 1'b0;
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end else if (!awHeld_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (wTake) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
				wHeld_q <= 1'b1;
				wready_q <= 1'b0;
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end else if (!wHeld_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------
	// write response
	// ---------------------------------------------
	// read-only targets answer okay and store nothing
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= `CCR_RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q <= isMapped(awAddr_q) ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// card specific data, writable bits
	// ---------------------------------------------
	assign tailMerged = laneMerge(tailWord, wData_q, wStrb_q);

	// clearing a one-way bit is refused and remembered
	assign ovrAttempt = doWrite && (awAddr_q == `CCR_OFF_TAIL)
		&& ((copy_q && !tailMerged[`CCR_COPY_BIT])
		|| (perm_q && !tailMerged[`CCR_PERM_BIT]));

	// geometry fields are constants, so only these can move
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			fmtGroup_q <= 1'b0;
			copy_q <= 1'b0;
			perm_q <= 1'b0;
			temp_q <= 1'b0;
			fmt_q <= FORMAT_INIT;
			cksum_q <= CHECKSUM_INIT;
		end else if (doWrite && awAddr_q == `CCR_OFF_TAIL) begin
			copy_q <= copy_q | tailMerged[`CCR_COPY_BIT];
			perm_q <= perm_q | tailMerged[`CCR_PERM_BIT];
			temp_q <= tailMerged[`CCR_TEMP_BIT];
			cksum_q <= tailMerged[`CCR_CKSUM_LSB +: 7];
			if (!IS_ROM) begin
				fmtGroup_q <= tailMerged[`CCR_FMT_GRP_BIT];
				fmt_q <= tailMerged[`CCR_FMT_LSB +: 2];
			end
		end
	end

	// ---------------------------------------------
	// access request and verdict
	// ---------------------------------------------
	// a request write starts one check, judged next cycle
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			req_q <= 14'h0000;
			checkGo_q <= 1'b0;
		end else begin
			checkGo_q <= doWrite && (awAddr_q == `CCR_OFF_REQ);
			if (doWrite && awAddr_q == `CCR_OFF_REQ) begin
				req_q <= reqMerge(req_q, wData_q, wStrb_q);
			end
		end
	end

	// request merge keeps unwritten lanes
	function [13:0] reqMerge;
		input [13:0] oldReq;
		input [31:0] newWord;
		input [3:0] strb;
		reg [31:0] merged;
		begin
			merged = laneMerge({18'h00000, oldReq}, newWord, strb);
			reqMerge = merged[13:0];
		end
	endfunction

	// verdict stands until the next request
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			resOk_q <= 1'b0;
			resProt_q <= 1'b0;
			resLen_q <= 1'b0;
		end else if (checkGo_q) begin
			resProt_q <= refuseProt;
			resLen_q <= refuseLen;
			resOk_q <= ~refuseProt & ~refuseLen;
		end
	end

	// ---------------------------------------------
	// overwrite attempt flag
	// ---------------------------------------------
	// set beats a same-cycle write-one clear
	assign resMerged = laneMerge(resWord, wData_q, wStrb_q);
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			overwrite_q <= 1'b0;
		end else if (ovrAttempt) begin
			overwrite_q <= 1'b1;
		end else if (doWrite && awAddr_q == `CCR_OFF_RES
			&& wStrb_q[0] && resMerged[`CCR_RES_OVR_BIT]) begin
			overwrite_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// read path
	// ---------------------------------------------
	// the feature word has no write path anywhere
	always @* begin
		case (araddr)
			`CCR_OFF_TAIL: readMux = tailWord;
			`CCR_OFF_FEAT_LO: readMux = featWord[31:0];
			`CCR_OFF_FEAT_HI: readMux = featWord[63:32];
			`CCR_OFF_REQ: readMux = {18'h00000, req_q};
			`CCR_OFF_RES: readMux = resWord;
			default: readMux = 32'h0000_0000;
		endcase
	end

	// one read in flight; data sampled when the address is taken
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CCR_RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= readMux;
			rresp_q <= isMapped(araddr) ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// ---------------------------------------------
	// card state outputs
	// ---------------------------------------------
	// registered so the pins never glitch on a write
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			locked_q <= 1'b0;
			groupAvail_q <= 1'b0;
		end else begin
			locked_q <= perm_q | temp_q;
			groupAvail_q <= GROUP_ENABLE;
		end
	end

	// ---------------------------------------------
	// port drive
	// ---------------------------------------------
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign contentLocked = locked_q;
	assign groupProtectAvail = groupAvail_q;
endmodule

// *** tb/ccr_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bus timing, feature word, tail word and card state checks
// ----------------------------------------
module ccr_props #(
	parameter [3:0] READ_BLK_LEN = 4'h9,
	parameter GROUP_ENABLE = 1'b1
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// write side
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	// read side
	input wire [7:0] araddr,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	input wire rready,
	// card state
	input wire contentLocked,
	input wire groupProtectAvail
);
	logic [7:0] rdAddr_q;
	logic copySeen_q;
	logic permSeen_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// address of the read in flight, and sticky bits once seen
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rdAddr_q <= 8'h00;
			copySeen_q <= 1'b0;
			permSeen_q <= 1'b0;
		end else begin
			if (arvalid && arready)
				rdAddr_q <= araddr;
			if (rvalid && rdAddr_q == 8'h00 && rdata[17])
				copySeen_q <= 1'b1;
			if (rvalid && rdAddr_q == 8'h00 && rdata[18])
				permSeen_q <= 1'b1;
		end
	end
	property p_bHold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write response dropped early");
	property p_bLat;
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
	endproperty
	a_bLat: assert property (p_bLat) else $error("write response late");
	property p_rLat;
		arvalid && arready |=> rvalid;
	endproperty
	a_rLat: assert property (p_rLat) else $error("read data late");
	property p_unmapR;
		arvalid && arready && araddr > 8'h10 |=> rresp == 2'h2 && rdata == 32'h0;
	endproperty
	a_unmapR: assert property (p_unmapR) else $error("unmapped read not refused");
	property p_groupAvail;
		$past(rst_n) |-> groupProtectAvail == GROUP_ENABLE;
	endproperty
	a_groupAvail: assert property (p_groupAvail) else $error("group protect flag");
	property p_widths;
		rvalid && rdAddr_q == 8'h08 |-> rdata[19:16] == 4'h5 && rdata[15:0] == 16'h0;
	endproperty
	a_widths: assert property (p_widths) else $error("bus widths field");
	property p_security;
		rvalid && rdAddr_q == 8'h08 |-> rdata[22:20] != 3'h0 && rdata[22:20] < 3'h3;
	endproperty
	a_security: assert property (p_security) else $error("security code");
	property p_wlen;
		rvalid && rdAddr_q == 8'h00 |-> rdata[14:11] == READ_BLK_LEN;
	endproperty
	a_wlen: assert property (p_wlen) else $error("write length differs");
	property p_copyStick;
		copySeen_q && rvalid && rdAddr_q == 8'h00 |-> rdata[17];
	endproperty
	a_copyStick: assert property (p_copyStick) else $error("copy flag cleared");
	property p_permLock;
		permSeen_q |-> contentLocked;
	endproperty
	a_permLock: assert property (p_permLock) else $error("permanent lock lost");
endmodule

// *** tb/ccr_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host controller on the register bus
// ----------------------------------------
module ccr_host_model (
	// clock
	input wire clk_sys,
	// write side
	output logic [7:0] awaddr,
	output logic [2:0] awprot,
	output logic awvalid,
	input wire awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	output logic bready,
	// read side
	output logic [7:0] araddr,
	output logic [2:0] arprot,
	output logic arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	output logic rready
);
	// idle bus at time zero
	initial begin
		awaddr = 8'h00;
		awprot = 3'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		arprot = 3'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// host recomputes the checksum on every rewrite
	function automatic logic [6:0] csum(input logic [21:0] v);
		csum = v[6:0] + v[13:7] + v[20:14] + {6'h0, v[21]};
	endfunction
	// released payload is inverted so a stale value cannot pass
	task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
				wstrb <= ~s;
			end
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	// whole-word write, every lane enabled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		wrs(a, d, 4'hf, r);
	endtask
	// one read, data taken at the handshake edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// *** tb/ccr_top_bench.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module ccr_top_bench;
	localparam [31:0] MAKER = 32'h1234_5678; // arbitrary value
	localparam [21:0] INIT = {2'h2, 4'h0, 1'b0, 4'hb, 3'h5, 1'b1, 7'h7f};
	// host sum over INIT, so the factory checksum matches the factory tail
	localparam [6:0] CKSUM0 = 7'h3c;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic clk_sys, rst_n, awready, wready, bvalid, bready, arready, rvalid, rready;
	logic awvalid, wvalid, arvalid, contentLocked, groupProtectAvail;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int num_errors, samples_checked;
	ccr_top #(.READ_BLK_LEN(4'hb), .GROUP_SIZE(7'h7f), .PROG_FACTOR(3'h5),
		.FORMAT_INIT(2'h2), .CHECKSUM_INIT(CKSUM0), .ERASE_STATE(1'b1),
		.MAKER_FIELD(MAKER)) ccr_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .contentLocked(contentLocked),
		.groupProtectAvail(groupProtectAvail));
	ccr_host_model ccr_host_model_inst (.clk_sys(clk_sys), .awaddr(awaddr),
		.awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	// 100 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic cmpVal(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", what, e, g);
			num_errors++;
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string what);
		logic [31:0] d;
		logic [1:0] r;
		ccr_host_model_inst.rd(a, d, r);
		cmpVal(what, e, d);
	endtask
	// rewrite the tail with a fresh checksum, then read back
	task automatic putTail(input logic [21:0] f, input logic [21:0] ef);
		logic [1:0] r;
		logic [6:0] c;
		c = ccr_host_model_inst.csum(f);
		ccr_host_model_inst.wr(8'h00, {3'h0, c, f}, r);
		cmpVal("tail write resp", 32'h0, {30'h0, r});
		rdChk(8'h00, {3'h0, c, ef}, "tail readback");
	endtask
	task automatic req(input logic [13:0] q, input logic [2:0] e);
		logic [1:0] r;
		logic [31:0] d;
		ccr_host_model_inst.wr(8'h0c, {18'h0, q}, r);
		ccr_host_model_inst.rd(8'h10, d, r);
		cmpVal("request result", {29'h0, e}, {29'h0, d[2:0]});
	endtask
	task automatic checkDefaults();
		rdChk(8'h00, {3'h0, CKSUM0, INIT}, "tail");
		rdChk(8'h04, MAKER, "feature low");
		rdChk(8'h08, 32'h00a5_0000, "feature high");
		cmpVal("group avail", 32'h1, {31'h0, groupProtectAvail});
		cmpVal("locked", 32'h0, {31'h0, contentLocked});
	endtask
	// writes to read-only places leave the factory values
	task automatic test_readonly();
		logic [1:0] r;
		logic [31:0] d;
		ccr_host_model_inst.wr(8'h04, 32'hffff_ffff, r);
		cmpVal("ro write resp", 32'h0, {30'h0, r});
		ccr_host_model_inst.wr(8'h08, 32'hffff_ffff, r);
		cmpVal("ro high write resp", 32'h0, {30'h0, r});
		ccr_host_model_inst.wr(8'h00, {3'h0, CKSUM0, INIT ^ 22'h00ffff}, r);
		checkDefaults();
		ccr_host_model_inst.wr(8'h20, 32'h1, r);
		cmpVal("unmapped write resp", 32'h2, {30'h0, r});
		ccr_host_model_inst.rd(8'h20, d, r);
		cmpVal("unmapped read resp", 32'h2, {30'h0, r});
		cmpVal("unmapped read data", 32'h0, d);
		$display("test readonly done");
	endtask
	// length limits for a 2048 byte block without partial writes
	task automatic test_length();
		req({2'b00, 12'd512}, 3'b001);
		req({2'b00, 12'd2048}, 3'b001);
		req({2'b00, 12'd1536}, 3'b001);
		req({2'b00, 12'd100}, 3'b100);
		req({2'b00, 12'd0}, 3'b100);
		req({2'b00, 12'd2560}, 3'b100);
		req({2'b01, 12'd100}, 3'b001);
		$display("test length done");
	endtask
	// every format code under both groups
	task automatic test_format();
		logic [21:0] f;
		for (int i = 0; i < 8; i++) begin
			f = INIT;
			f[21:20] = i[1:0];
			f[16] = i[2];
			putTail(f, f);
		end
		putTail(INIT, INIT);
		$display("test format done");
	endtask
	// temporary lock, copy flag and permanent lock in turn
	task automatic test_protect();
		logic [31:0] d;
		logic [1:0] r;
		putTail(INIT | 22'h080000, INIT | 22'h080000);
		cmpVal("temp locked", 32'h1, {31'h0, contentLocked});
		req({2'b00, 12'd512}, 3'b010);
		req({2'b11, 12'd512}, 3'b001);
		putTail(INIT, INIT);
		cmpVal("temp unlocked", 32'h0, {31'h0, contentLocked});
		req({2'b00, 12'd512}, 3'b001);
		putTail(INIT | 22'h020000, INIT | 22'h020000);
		putTail(INIT, INIT | 22'h020000);
		ccr_host_model_inst.rd(8'h10, d, r);
		cmpVal("overwrite flag", 32'h1, {31'h0, d[3]});
		// write-one clear needs lane 0; another lane must leave the flag
		ccr_host_model_inst.wrs(8'h10, 32'h0000_0008, 4'h2, r);
		ccr_host_model_inst.rd(8'h10, d, r);
		cmpVal("flag lane off", 32'h1, {31'h0, d[3]});
		ccr_host_model_inst.wrs(8'h10, 32'h0000_0008, 4'h1, r);
		ccr_host_model_inst.rd(8'h10, d, r);
		cmpVal("flag cleared", 32'h0, {31'h0, d[3]});
		putTail(INIT | 22'h060000, INIT | 22'h060000);
		putTail(INIT | 22'h020000, INIT | 22'h060000);
		ccr_host_model_inst.rd(8'h10, d, r);
		cmpVal("perm clear flag", 32'h1, {31'h0, d[3]});
		cmpVal("perm locked", 32'h1, {31'h0, contentLocked});
		req({2'b01, 12'd512}, 3'b010);
		req({2'b10, 12'd512}, 3'b001);
		$display("test protect done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		checkDefaults();
		$display("test reset done");
		test_readonly();
		test_length();
		test_format();
		test_protect();
		test_done();
	end
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#500000;
		num_errors++;
		test_done();
	end
endmodule
bind ccr_top ccr_props #(.READ_BLK_LEN(READ_BLK_LEN), .GROUP_ENABLE(GROUP_ENABLE))
	ccr_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.contentLocked(contentLocked), .groupProtectAvail(groupProtectAvail));
